// ===== rtl/spbm_top.sv
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "spbm_regs.svh"

// Functional notes
// - enabled operations happen only on the rising clock edge, inputs registered there
// - enable low holds data output and blocks writes
// - enabled edge with store strobe writes write data at the word select
// - enabled edge without store strobe reads addressed word to read data
// - static write mode choice, mirror-new default; older family mirror-new only
// - mirror-new: written value also appears on read data
// - show-old: previous contents at write address appear on read data
// - hold-output: write leaves read data unchanged
// - output preset loads preset value; zero on older family, user value on newer
// - preset never changes storage nor disturbs a same-cycle write
// - preset ignored while port enable is inactive
// - default read-write; read-only configuration drops strobe and write data
// - accept-ready is high except while port enable is inactive
// - result-valid follows fresh-request by exactly the read latency
// - mirror-new, no extra registers: written data out at first edge
// - mirror-new: second edge with one register option, third with both
// - data width one to 256 bits, buses always vectors
// - depth two words up to family maximum
// - storage holds initial contents right after configuration
// - show-old, no registers: old contents out at first edge
// - input registering adds one stage to data, address and strobe
module spbm_top
    import spbm_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int DEPTH = 16,
    parameter int ADDR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1,
    parameter spbm_family_t FAMILY = SPBM_FAMILY_NEW,
    parameter spbm_wmode_t WRITE_MODE = SPBM_MIRROR_NEW,
    parameter bit READ_ONLY = 1'b0,
    parameter bit IN_REG = 1'b0,
    parameter bit OUT_REG = 1'b0,
    parameter logic [DATA_W-1:0] INIT_WORD = '0,
    parameter logic [DATA_W-1:0] PRESET_INIT = '0
) (
    // clock, reset, clock enable
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // memory port
    input wire logic en_in,
    input wire logic store_in,
    input wire logic [ADDR_W-1:0] word_sel_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic output_preset_in,
    output logic [DATA_W-1:0] rdata_out,
    // handshake
    input wire logic fresh_request_in,
    output logic accept_ready_out,
    output logic result_valid_out,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out
);
    // =================================================================
    // configuration
    localparam int LATENCY = `SPBM_BASE_LATENCY + int'(IN_REG) + int'(OUT_REG);
    localparam int MAX_DEPTH = (FAMILY == SPBM_FAMILY_OLD) ? `SPBM_MAX_DEPTH_OLD :
        `SPBM_MAX_DEPTH_NEW;
    localparam int WORDS = (DEPTH < 2) ? 2 : ((DEPTH > MAX_DEPTH) ? MAX_DEPTH : DEPTH);
    // the older family only knows mirror-new, whatever was asked for
    localparam spbm_wmode_t MODE = (FAMILY == SPBM_FAMILY_OLD) ? SPBM_MIRROR_NEW :
        WRITE_MODE;

    // =================================================================
    // storage, preloaded for configuration time
    // the preload sits in the declaration so that the write process stays
    // the only process that assigns the array
    logic [DATA_W-1:0] mem [WORDS] = '{default: INIT_WORD};

    // =================================================================
    // pipeline advance: nothing moves with clock enable or port enable low
    logic adv;
    assign adv = ce_in && en_in;

    // =================================================================
    // optional input stage
    // registered inputs cost one cycle of latency but ease timing into the array
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] wdata_s;
    logic store_s;
    logic store_eff;

    generate
        if (IN_REG) begin : g_in_reg
            logic [ADDR_W-1:0] addr_reg;
            logic [DATA_W-1:0] wdata_reg;
            logic store_reg;

            always_ff @(posedge mclk_in) begin
                if (rst_in) begin
                    addr_reg <= '0;
                    wdata_reg <= '0;
                    store_reg <= 1'b0;
                end else if (adv) begin
                    addr_reg <= word_sel_in;
                    wdata_reg <= wdata_in;
                    store_reg <= store_in;
                end
            end

            assign addr_s = addr_reg;
            assign wdata_s = wdata_reg;
            assign store_s = store_reg;
        end else begin : g_in_direct
            assign addr_s = word_sel_in;
            assign wdata_s = wdata_in;
            assign store_s = store_in;
        end
    endgenerate

    // a read-only port never writes, so its strobe and data pins are dead
    assign store_eff = store_s && !READ_ONLY;

    // =================================================================
    // preset value, low word programmable on the newer family
    // bits above the software word keep the build-time preset value
    logic [31:0] preset_reg;
    logic [DATA_W-1:0] preset_val;

    always_comb begin
        preset_val = '0;
        if (FAMILY == SPBM_FAMILY_NEW) begin
            for (int i = 0; i < DATA_W; i++) begin
                if (i < `SPBM_PRESET_SW_W) begin
                    preset_val[i] = preset_reg[i];
                end else begin
                    preset_val[i] = PRESET_INIT[i];
                end
            end
        end
    end

    // =================================================================
    // storage write, independent of the preset
    always_ff @(posedge mclk_in) begin
        if (adv && store_eff) begin
            mem[addr_s] <= wdata_s;
        end
    end

    // =================================================================
    // output latch
    logic [DATA_W-1:0] latch_reg;
    logic [DATA_W-1:0] latch_next;

    // show-old reads the array before this edge's write lands, since the write
    // is a non-blocking update in its own process
    always_comb begin
        latch_next = latch_reg;
        if (output_preset_in) begin
            latch_next = preset_val;
        end else if (store_eff) begin
            case (MODE)
                SPBM_MIRROR_NEW: latch_next = wdata_s;
                SPBM_SHOW_OLD: latch_next = mem[addr_s];
                SPBM_HOLD_OUT: latch_next = latch_reg;
                default: latch_next = wdata_s;
            endcase
        end else begin
            latch_next = mem[addr_s];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            latch_reg <= '0;
        end else if (adv) begin
            latch_reg <= latch_next;
        end
    end

    // =================================================================
    // optional output stage
    // the stage loads the preset directly, so a preset still shows after one
    // enabled edge with the extra register in place
    generate
        if (OUT_REG) begin : g_out_reg
            logic [DATA_W-1:0] out_reg;

            always_ff @(posedge mclk_in) begin
                if (rst_in) begin
                    out_reg <= '0;
                end else if (adv) begin
                    out_reg <= output_preset_in ? preset_val : latch_reg;
                end
            end

            assign rdata_out = out_reg;
        end else begin : g_out_direct
            assign rdata_out = latch_reg;
        end
    endgenerate

    // =================================================================
    // handshake
    // result-valid rides a delay line that only shifts on enabled edges, so a
    // stalled port never drops or repeats a request
    spbm_lat_if lat ();

    assign lat.adv = adv;
    assign lat.req = fresh_request_in;

    spbm_delay #(
        .LATENCY(LATENCY)
    ) u_delay (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .lat(lat.dly)
    );

    assign result_valid_out = lat.valid;
    assign accept_ready_out = en_in;

    // =================================================================
    // activity counters and last address, for software visibility
    logic [31:0] wcount_reg;
    logic [31:0] rcount_reg;
    logic [31:0] pcount_reg;
    logic [ADDR_W-1:0] laddr_reg;
    logic apb_wr;
    logic apb_rd_setup;
    logic [2:0] clr;

    assign apb_wr = ce_in && psel_in && penable_in && pwrite_in;
    assign apb_rd_setup = ce_in && psel_in && !penable_in;
    assign clr[0] = apb_wr && (paddr_in == `SPBM_OFF_CLEAR) && pwdata_in[`SPBM_CLR_WCOUNT_BIT];
    assign clr[1] = apb_wr && (paddr_in == `SPBM_OFF_CLEAR) && pwdata_in[`SPBM_CLR_RCOUNT_BIT];
    assign clr[2] = apb_wr && (paddr_in == `SPBM_OFF_CLEAR) && pwdata_in[`SPBM_CLR_PCOUNT_BIT];

    // an event in the clearing cycle is kept: the count restarts at one
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            wcount_reg <= `SPBM_COUNT_RST;
        end else if (ce_in) begin
            if (clr[0]) begin
                wcount_reg <= {31'h0000_0000, adv && store_eff};
            end else if (adv && store_eff) begin
                wcount_reg <= wcount_reg + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rcount_reg <= `SPBM_COUNT_RST;
        end else if (ce_in) begin
            if (clr[1]) begin
                rcount_reg <= {31'h0000_0000, adv && !store_eff};
            end else if (adv && !store_eff) begin
                rcount_reg <= rcount_reg + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pcount_reg <= `SPBM_COUNT_RST;
        end else if (ce_in) begin
            if (clr[2]) begin
                pcount_reg <= {31'h0000_0000, adv && output_preset_in};
            end else if (adv && output_preset_in) begin
                pcount_reg <= pcount_reg + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            laddr_reg <= '0;
        end else if (adv) begin
            laddr_reg <= addr_s;
        end
    end

    // =================================================================
    // apb: zero wait states, read data captured in the setup cycle
    logic [31:0] rd_mux;
    logic rd_hit;
    logic [31:0] laddr_word;
    logic [31:0] status_word;

    always_comb begin
        laddr_word = `SPBM_WORD_ZERO;
        laddr_word[ADDR_W-1:0] = laddr_reg;
        status_word = `SPBM_WORD_ZERO;
        status_word[`SPBM_ST_READY_BIT] = accept_ready_out;
        status_word[`SPBM_ST_VALID_BIT] = result_valid_out;
        status_word[`SPBM_ST_EN_BIT] = en_in;
        status_word[`SPBM_ST_RO_BIT] = READ_ONLY;
        status_word[`SPBM_ST_MODE_MSB:`SPBM_ST_MODE_LSB] = MODE;
        status_word[`SPBM_ST_FAMILY_BIT] = FAMILY;
    end

    always_comb begin
        rd_mux = `SPBM_WORD_ZERO;
        rd_hit = 1'b1;
        case (paddr_in)
            `SPBM_OFF_PRESET: rd_mux = preset_reg;
            `SPBM_OFF_STATUS: rd_mux = status_word;
            `SPBM_OFF_WCOUNT: rd_mux = wcount_reg;
            `SPBM_OFF_RCOUNT: rd_mux = rcount_reg;
            `SPBM_OFF_PCOUNT: rd_mux = pcount_reg;
            `SPBM_OFF_LADDR: rd_mux = laddr_word;
            `SPBM_OFF_CLEAR: rd_mux = `SPBM_WORD_ZERO;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            prdata_out <= `SPBM_WORD_ZERO;
            pslverr_out <= 1'b0;
        end else if (apb_rd_setup) begin
            prdata_out <= pwrite_in ? `SPBM_WORD_ZERO : rd_mux;
            pslverr_out <= !rd_hit;
        end
    end

    // the older family has a fixed zero preset, so the register is inert there
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            preset_reg <= `SPBM_PRESET_RST;
        end else if (apb_wr && (paddr_in == `SPBM_OFF_PRESET)) begin
            preset_reg <= pwdata_in;
        end
    end

    // pready follows the clock enable: a frozen block stretches every access
    assign pready_out = ce_in;
endmodule // spbm_top

// ===== rtl/spbm_regs.svh
`ifndef SPBM_REGS_SVH
`define SPBM_REGS_SVH

// =====================================================================
// register offsets, byte addresses on the apb side
`define SPBM_OFF_PRESET 8'h00
`define SPBM_OFF_STATUS 8'h04
`define SPBM_OFF_WCOUNT 8'h08
`define SPBM_OFF_RCOUNT 8'h0c
`define SPBM_OFF_PCOUNT 8'h10
`define SPBM_OFF_LADDR 8'h14
`define SPBM_OFF_CLEAR 8'h18

// =====================================================================
// reset values
`define SPBM_PRESET_RST 32'h0000_0000
`define SPBM_COUNT_RST 32'h0000_0000
`define SPBM_WORD_ZERO 32'h0000_0000

// =====================================================================
// status field positions
`define SPBM_ST_READY_BIT 0
`define SPBM_ST_VALID_BIT 1
`define SPBM_ST_EN_BIT 2
`define SPBM_ST_RO_BIT 3
`define SPBM_ST_MODE_LSB 4
`define SPBM_ST_MODE_MSB 5
`define SPBM_ST_FAMILY_BIT 6

// =====================================================================
// clear register field positions
`define SPBM_CLR_WCOUNT_BIT 0
`define SPBM_CLR_RCOUNT_BIT 1
`define SPBM_CLR_PCOUNT_BIT 2

// =====================================================================
// fixed widths and limits
`define SPBM_PRESET_SW_W 32
`define SPBM_BASE_LATENCY 1
`define SPBM_MAX_DEPTH_OLD 262144
`define SPBM_MAX_DEPTH_NEW 1048576

`endif

// ===== rtl/spbm_pkg.sv
package spbm_pkg;

    // =================================================================
    // write modes
    typedef enum logic [1:0] {
        SPBM_MIRROR_NEW = 2'b00,
        SPBM_SHOW_OLD = 2'b01,
        SPBM_HOLD_OUT = 2'b10
    } spbm_wmode_t;

    // =================================================================
    // target families
    typedef enum logic {
        SPBM_FAMILY_OLD = 1'b0,
        SPBM_FAMILY_NEW = 1'b1
    } spbm_family_t;

endpackage

// ===== rtl/spbm_lat_if.sv
`timescale 1ns/1ns

interface spbm_lat_if;
    logic adv;
    logic req;
    logic valid;

    modport src (output adv, output req, input valid);
    modport dly (input adv, input req, output valid);
endinterface

// ===== rtl/spbm_delay.sv
`timescale 1ns/1ns

module spbm_delay #(
    parameter int LATENCY = 1
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // link to the memory core
    spbm_lat_if.dly lat
);
    // =================================================================
    // fresh-request delay line, advances only with the memory pipeline
    logic [LATENCY-1:0] line_reg;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            line_reg <= '0;
        end else if (ce_in && lat.adv) begin
            // the cast drops the oldest stage, which also covers a one-stage line
            line_reg <= LATENCY'({line_reg, lat.req});
        end
    end

    assign lat.valid = line_reg[LATENCY-1];
endmodule // spbm_delay

// ===== test/spbm_top_asserts.sv
`timescale 1ns/1ns

// ====================
// port checks; the mirror check is armed only for mirror-new with no extra stages
module spbm_top_asserts #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 4,
    parameter bit MIRROR = 1'b1
) (
    // clock and control
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // memory port
    input wire logic en_in,
    input wire logic store_in,
    input wire logic [ADDR_W-1:0] word_sel_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic output_preset_in,
    input wire logic [DATA_W-1:0] rdata_out,
    input wire logic fresh_request_in,
    input wire logic accept_ready_out,
    input wire logic result_valid_out,
    // apb
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic [7:0] paddr_in,
    input wire logic pslverr_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    edge_only_a: assert property (!ce_in |=> $stable(rdata_out) && $stable(result_valid_out))
        else $error("outputs moved while clock enable low");
    hold_off_a: assert property (ce_in && !en_in |=> $stable(rdata_out))
        else $error("read data moved while port disabled");
    mirror_write_a: assert property (MIRROR && ce_in && en_in && store_in
        && !output_preset_in |=> rdata_out == $past(wdata_in))
        else $error("write data not mirrored on read data");
    read_back_a: assert property (ce_in && en_in && store_in ##1 ce_in && en_in
        && !store_in && !output_preset_in && $stable(word_sel_in)
        |=> rdata_out == $past(wdata_in, 2))
        else $error("read after write returned other data");
    preset_off_a: assert property (ce_in && !en_in && output_preset_in |=> $stable(rdata_out))
        else $error("preset acted while port disabled");
    ready_tracks_a: assert property (accept_ready_out == en_in)
        else $error("accept ready differs from port enable");
    valid_lag_a: assert property (ce_in && en_in
        |=> result_valid_out == $past(fresh_request_in))
        else $error("result valid does not follow fresh request");
    unmapped_err_a: assert property (psel_in && !penable_in && ce_in && paddr_in > 8'h18
        |=> pslverr_out)
        else $error("unmapped apb address gave no error");
endmodule // spbm_top_asserts

bind spbm_top spbm_top_asserts #(.DATA_W(DATA_W), .ADDR_W(ADDR_W),
    .MIRROR(MODE == SPBM_MIRROR_NEW && !IN_REG && !OUT_REG)) i_chk (
    .mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in), .en_in(en_in), .store_in(store_in),
    .word_sel_in(word_sel_in), .wdata_in(wdata_in), .output_preset_in(output_preset_in),
    .rdata_out(rdata_out), .fresh_request_in(fresh_request_in),
    .accept_ready_out(accept_ready_out), .result_valid_out(result_valid_out),
    .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in), .pslverr_out(pslverr_out));

// ===== test/spbm_user.sv
`timescale 1ns/1ns

// ====================
// user logic on the far side of the memory port
module spbm_user #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 4
) (
    // clock
    input wire logic mclk_in,
    // memory port controls
    output logic en_out,
    output logic store_out,
    output logic [ADDR_W-1:0] word_sel_out,
    output logic [DATA_W-1:0] wdata_out,
    output logic preset_out,
    output logic fresh_out
);
    initial begin
        {en_out, store_out, preset_out, fresh_out} = 4'h0;
        word_sel_out = '0;
        wdata_out = '0;
    end

    // one port cycle, c = {enable, store, preset, fresh}, all active high
    task automatic cyc(input logic [3:0] c, input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        {en_out, store_out, preset_out, fresh_out} <= c;
        // a disabled port sees changing junk, so a held value cannot mask a fault
        word_sel_out <= c[3] ? ADDR_W'(a) : ~word_sel_out;
        wdata_out <= c[3] ? DATA_W'(d) : ~wdata_out;
        #1;
    endtask
endmodule // spbm_user

// ===== test/test_single_port_block_memory.sv
`timescale 1ns/1ns

// ====================
// bench: each rdata and valid check sees the port cycle issued one call earlier, a ready check the current one
module test_single_port_block_memory import spbm_pkg::*;;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic en, store, preset, fresh, ready, valid, pready, pslverr, err;
    logic [3:0] word_sel;
    logic [7:0] wdata, rdata, rdata_so;
    logic [31:0] prdata, rd;
    int errors = 0;
    int samples_checked = 0;

    always #4 mclk_in = ~mclk_in;

    spbm_user i_user (.mclk_in(mclk_in), .en_out(en), .store_out(store),
        .word_sel_out(word_sel), .wdata_out(wdata), .preset_out(preset), .fresh_out(fresh));
    spbm_top i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in), .en_in(en),
        .store_in(store), .word_sel_in(word_sel), .wdata_in(wdata), .output_preset_in(preset),
        .rdata_out(rdata), .fresh_request_in(fresh), .accept_ready_out(ready),
        .result_valid_out(valid), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr));
    // show-old twin on the same stimulus, only its read data is judged
    spbm_top #(.WRITE_MODE(SPBM_SHOW_OLD)) i_dut_so (.mclk_in(mclk_in), .rst_in(rst_in),
        .ce_in(ce_in), .en_in(en), .store_in(store), .word_sel_in(word_sel), .wdata_in(wdata),
        .output_preset_in(preset), .rdata_out(rdata_so), .fresh_request_in(fresh),
        .accept_ready_out(), .result_valid_out(), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(),
        .pready_out(), .pslverr_out());

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_in);
        penable <= 1'b1;
        do @(posedge mclk_in); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic t_write();
        check("rdata", 32'h0, 32'(rdata));
        i_user.cyc(4'h8, 4'h5, 8'h00);
        i_user.cyc(4'hc, 4'h3, 8'ha5);
        check("rdata", 32'h0, 32'(rdata));
        i_user.cyc(4'h8, 4'h3, 8'h00);
        check("rdata", 32'ha5, 32'(rdata));
        check("rdata_so", 32'h0, 32'(rdata_so));
        i_user.cyc(4'hc, 4'h4, 8'h3c);
        check("rdata", 32'ha5, 32'(rdata));
        i_user.cyc(4'h4, 4'h3, 8'hff);
        check("rdata", 32'h3c, 32'(rdata));
        check("rdata_so", 32'h0, 32'(rdata_so));
        check("ready", 32'h0, 32'(ready));
        i_user.cyc(4'h8, 4'h3, 8'h00);
        check("rdata", 32'h3c, 32'(rdata));
        check("ready", 32'h1, 32'(ready));
        i_user.cyc(4'hc, 4'h8, 8'h11);
        check("rdata", 32'ha5, 32'(rdata));
        ce_in <= 1'b0;
        i_user.cyc(4'h0, 4'h0, 8'h00);
        check("pready", 32'h0, 32'(pready));
        ce_in <= 1'b1;
        i_user.cyc(4'h8, 4'h8, 8'h00);
        i_user.cyc(4'h0, 4'h0, 8'h00);
        check("rdata", 32'h0, 32'(rdata));
        $display("test write and read done");
    endtask

    task automatic t_preset();
        apb(1'b1, 8'h00, 32'h0000_005a);
        i_user.cyc(4'he, 4'h6, 8'h77);
        i_user.cyc(4'h8, 4'h6, 8'h00);
        check("rdata", 32'h5a, 32'(rdata));
        i_user.cyc(4'ha, 4'h6, 8'h00);
        check("rdata", 32'h77, 32'(rdata));
        i_user.cyc(4'h8, 4'h6, 8'h00);
        check("rdata", 32'h5a, 32'(rdata));
        i_user.cyc(4'h2, 4'h6, 8'h00);
        i_user.cyc(4'h0, 4'h0, 8'h00);
        check("rdata", 32'h77, 32'(rdata));
        $display("test preset done");
    endtask

    task automatic t_valid();
        i_user.cyc(4'h9, 4'h0, 8'h00);
        i_user.cyc(4'h8, 4'h0, 8'h00);
        check("valid", 32'h1, 32'(valid));
        i_user.cyc(4'h1, 4'h0, 8'h00);
        check("valid", 32'h0, 32'(valid));
        i_user.cyc(4'h0, 4'h0, 8'h00);
        check("valid", 32'h0, 32'(valid));
        $display("test handshake done");
    endtask

    task automatic t_apb();
        apb(1'b0, 8'h04, 32'h0);
        check("status", {25'h0, SPBM_FAMILY_NEW, SPBM_MIRROR_NEW, 4'h0}, rd);
        apb(1'b0, 8'h00, 32'h0);
        check("preset", 32'h5a, rd);
        apb(1'b0, 8'h1c, 32'h0);
        check("slverr", 32'h1, 32'(err));
        check("prdata", 32'h0, rd);
        apb(1'b0, 8'h08, 32'h0);
        check("wcount", 32'h3, rd);
        apb(1'b0, 8'h10, 32'h0);
        check("pcount", 32'h2, rd);
        $display("test registers done");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge mclk_in);
        rst_in <= 1'b0;
        t_write();
        t_preset();
        t_valid();
        t_apb();
        finish_test();
    end

    // the sequence needs well under 200 cycles
    initial begin
        repeat (5000) @(posedge mclk_in);
        errors++;
        finish_test();
    end
endmodule // test_single_port_block_memory
